/* shared/seap_cfg.svh */
// Constants for the serial-bus nonvolatile byte memory command block.
// Assumes inclusion by bare name from the package and the top module.
// Summary of operation
// R01 - Status write changes only the lock bit and the two guard bits.
// R02 - Status bits 6 to 4 always read as zero.
// R03 - Host sets the write enable latch before a status write.
// R04 - Programming starts when select rises after a whole byte, before the next clock.
// R05 - Write in progress reads one while programming; latch clears at completion.
// R06 - Lock and guard bits keep old values until status programming completes.
// R07 - Lock bit set with protect pin low forbids any status write.
// R08 - Status write is cancelled unless exactly 16 clocks arrive while selected.
// R09 - Read loads the address, outputs bytes, increments and wraps; bit 15 ignored.
// R10 - Select rising ends a read anytime; read refused while programming.
// R11 - Page write takes 64 bytes; only the low 6 address bits advance and wrap.
// R12 - Memory write refused without latch, while programming, or into guarded area.
// R13 - Memory write cancelled unless clocks equal 24 plus 8 per data byte.
// R14 - Memory programming completion clears write in progress and the latch.
// R15 - Guard bits 00 none, 01 6000h-7FFFh, 10 4000h-7FFFh, 11 everything.
// R16 - With lock bit zero the status register stays writable whatever the pin.
// R17 - Protect pin high leaves only the guard bits restricting writes.
// R18 - Latch clear refuses all writes; guarded blocks never writable.
// R19 - Hold tri-states the output and ignores data and clock; host keeps select low.
// R20 - Hold pin change while clock low takes effect at once.
// R21 - Hold pin change while clock high takes effect at the next falling edge.
// R22 - Select rising during hold abandons the operation and deselects.
// R23 - Input sampled on rising clock edges MSB first; output changes on falling.
// R24 - One-byte commands 06, 04, 05, 01, 03, 02; an unknown code deselects the device.
// R25 - Status layout: lock bit 7, guards bits 3 and 2, latch 1, progress 0.
// R26 - Only the set-enable command sets the latch; disable and programming clear it.
// R27 - Programming time is a parameterised cycle count with progress held high.
`ifndef SEAP_CFG_SVH
`define SEAP_CFG_SVH

`define SEAP_CLK_HZ          50000000
`define SEAP_PROG_CYCLES_DEF 100
`define SEAP_PROG_CNT_W      24
`define SEAP_PAGE_BYTES      64

`define SEAP_CMD_SET_WE      8'h06
`define SEAP_CMD_CLEAR_WE    8'h04
`define SEAP_CMD_STATUS_RD   8'h05
`define SEAP_CMD_STATUS_WR   8'h01
`define SEAP_CMD_MEM_RD      8'h03
`define SEAP_CMD_MEM_WR      8'h02

`define SEAP_SR_LOCK_BIT     7
`define SEAP_SR_GUARD_HI     3
`define SEAP_SR_GUARD_LO     2

`define SEAP_GUARD_QUARTER   15'h6000
`define SEAP_GUARD_HALF      15'h4000

`define SEAP_PIN_RST         5'h13

`define SEAP_REG_STATUS      8'h00
`define SEAP_REG_CTRL        8'h04
`define SEAP_CTRL_RST        1'h1
`define SEAP_RESP_OKAY       2'h0
`define SEAP_RESP_SLVERR     2'h2

`endif

/* shared/seap_pkg.sv */
// Types shared by the serial memory command block.
// Assumes the constants header sits on the include path.
`include "seap_cfg.svh"
package seap_pkg;

	typedef enum logic [3:0] {
		S_IDLE,
		S_CMD,
		S_ADDR_HI,
		S_ADDR_LO,
		S_RDATA,
		S_WDATA,
		S_SR_DATA,
		S_STAT_OUT,
		S_WAIT,
		S_IGNORE
	} seap_state_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic wp_n;
		logic hold_n;
	} seap_pins_t;

endpackage

/* src/seap_top.sv */
// Serial-bus byte memory: command decode, protection, hold and a 32 KiB array.
// Assumes link pins are asynchronous to aclk and that aclk is well above the link clock.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "seap_cfg.svh"
module seap_top
	import seap_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `SEAP_PROG_CYCLES_DEF
) (
	input  wire logic        aclk,          // System clock.
	input  wire logic        aresetn,       // Synchronous reset, active low.
	input  wire logic        ce,            // Clock enable; low freezes all state.
	input  wire logic        cs_n,          // Select pin, active low.
	input  wire logic        sck,           // Link clock pin.
	input  wire logic        si,            // Serial data into the device.
	input  wire logic        wp_n,          // Protect pin, active low.
	input  wire logic        hold_n,        // Hold pin, active low.
	output logic             so,            // Serial data out of the device.
	output logic             so_oe,         // High while the device drives so.
	input  wire logic [7:0]  s_axi_awaddr,  // Write address.
	input  wire logic        s_axi_awvalid, // Write address valid.
	output logic             s_axi_awready, // Write address ready.
	input  wire logic [31:0] s_axi_wdata,   // Write data.
	input  wire logic [3:0]  s_axi_wstrb,   // Write byte enables.
	input  wire logic        s_axi_wvalid,  // Write data valid.
	output logic             s_axi_wready,  // Write data ready.
	output logic [1:0]       s_axi_bresp,   // Write response.
	output logic             s_axi_bvalid,  // Write response valid.
	input  wire logic        s_axi_bready,  // Write response ready.
	input  wire logic [7:0]  s_axi_araddr,  // Read address.
	input  wire logic        s_axi_arvalid, // Read address valid.
	output logic             s_axi_arready, // Read address ready.
	output logic [31:0]      s_axi_rdata,   // Read data.
	output logic [1:0]       s_axi_rresp,   // Read response.
	output logic             s_axi_rvalid,  // Read data valid.
	input  wire logic        s_axi_rready   // Read data ready.
);

	localparam logic [`SEAP_PROG_CNT_W-1:0] PROG_LAST = `SEAP_PROG_CNT_W'(PROG_CYCLES - 1);
	localparam logic [4:0] PIN_RST = `SEAP_PIN_RST;

	function automatic logic seap_guarded(input logic [14:0] a, input logic [1:0] bp);
		seap_guarded = (bp == 2'h3) ||
			(bp == 2'h2 && a >= `SEAP_GUARD_HALF) ||
			(bp == 2'h1 && a >= `SEAP_GUARD_QUARTER);
	endfunction

	logic [7:0]  mem [0:32767];
	logic [7:0]  pbuf [0:`SEAP_PAGE_BYTES-1];

	logic [4:0]  pin_meta_r;
	logic [4:0]  pin_sync_r;
	logic        sck_d_r;
	logic        sel_d_r;
	logic        hold_r;
	logic        link_en_r;
	seap_state_t state_r;
	seap_state_t state_nxt;
	logic [2:0]  bit_idx_r;
	logic [7:0]  byte_cnt_r;
	logic [7:0]  shift_r;
	logic [7:0]  cmd_r;
	logic [14:0] addr_r;
	logic [8:0]  page_r;
	logic [7:0]  new_sr_r;
	logic [7:0]  out_byte_r;
	logic [63:0] page_mask_r;
	logic        sr_lock_r;
	logic [1:0]  sr_bp_r;
	logic        wel_r;
	logic        wel_nxt;
	logic        wip_r;
	logic        prog_mem_r;
	logic [`SEAP_PROG_CNT_W-1:0] prog_cnt_r;
	logic        so_r;
	logic        so_oe_r;

	// Two flip-flops per pin; only the second stage is read below.
	wire [4:0] pin_raw = {cs_n, sck, si, wp_n, hold_n};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_meta_r[gi] <= PIN_RST[gi];
					pin_sync_r[gi] <= PIN_RST[gi];
				end else if (ce) begin
					pin_meta_r[gi] <= pin_raw[gi];
					pin_sync_r[gi] <= pin_meta_r[gi];
				end
			end
		end
	endgenerate

	seap_pins_t pin_s;
	assign pin_s = seap_pins_t'(pin_sync_r);

	wire       selected   = ~pin_s.cs_n & link_en_r;
	wire       cs_start   = selected & ~sel_d_r;
	wire       cs_end     = ~selected & sel_d_r;
	// Clock edges are dropped during hold, so data and clock are ignored.
	wire       sck_rise   = selected & ~hold_r & pin_s.sck & ~sck_d_r;   // [R19] [R23]
	wire       sck_fall   = selected & ~hold_r & ~pin_s.sck & sck_d_r;   // [R23]
	// Hold follows the pin only while the clock is low, so a change made with the
	// clock high waits for the falling edge.
	wire       hold_nxt   = ~selected ? 1'b0 : (pin_s.sck ? hold_r : ~pin_s.hold_n); // [R20] [R21]
	wire [7:0] rx_byte    = {shift_r[6:0], pin_s.si};
	wire       byte_done  = sck_rise & (bit_idx_r == 3'h7);
	wire       hardware_guard_mode        = sr_lock_r & ~pin_s.wp_n;                      // [R07] [R16] [R17]
	wire [7:0] status_byte = {sr_lock_r, 3'h0, sr_bp_r, wel_r, wip_r};   // [R02] [R25]
	wire [14:0] lo_addr   = {addr_r[14:8], rx_byte};
	wire        write_ok  = wel_r & ~wip_r & ~seap_guarded(lo_addr, sr_bp_r); // [R12] [R18]
	wire [14:0] rd_addr   = (state_r == S_ADDR_LO) ? lo_addr : addr_r + 15'h1;
	wire [7:0]  rd_data   = mem[rd_addr];
	wire        out_state = (state_r == S_RDATA) | (state_r == S_STAT_OUT);

	// A raise of select while held abandons the operation without starting anything.
	wire end_ok     = cs_end & ~hold_r;                                   // [R22]
	wire exact8     = (byte_cnt_r == 8'h1) & (bit_idx_r == 3'h0);
	wire exact16    = (byte_cnt_r == 8'h2) & (bit_idx_r == 3'h0);        // [R08]
	wire in_wait    = end_ok & (state_r == S_WAIT);
	wire we_set     = in_wait & (cmd_r == `SEAP_CMD_SET_WE) & exact8;    // [R26]
	wire we_clr     = in_wait & (cmd_r == `SEAP_CMD_CLEAR_WE) & exact8;  // [R26]
	wire sr_start   = in_wait & (cmd_r == `SEAP_CMD_STATUS_WR) & exact16 &
		wel_r & ~hardware_guard_mode & ~wip_r;                                           // [R04] [R07] [R18]
	wire mem_start  = end_ok & (state_r == S_WDATA) & (bit_idx_r == 3'h0) &
		(byte_cnt_r >= 8'h4);                                            // [R04] [R13]
	wire prog_last  = wip_r & (prog_cnt_r == PROG_LAST);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			S_CMD: begin
				case (rx_byte)
					`SEAP_CMD_SET_WE, `SEAP_CMD_CLEAR_WE: state_nxt = S_WAIT;
					`SEAP_CMD_STATUS_RD: state_nxt = S_STAT_OUT;
					`SEAP_CMD_STATUS_WR: state_nxt = S_SR_DATA;
					`SEAP_CMD_MEM_RD: state_nxt = wip_r ? S_IGNORE : S_ADDR_HI; // [R10]
					`SEAP_CMD_MEM_WR: state_nxt = S_ADDR_HI;
					default: state_nxt = S_IGNORE;                          // [R24]
				endcase
			end
			S_ADDR_HI: state_nxt = S_ADDR_LO;
			S_ADDR_LO: begin
				if (cmd_r == `SEAP_CMD_MEM_RD) begin
					state_nxt = S_RDATA;
				end else begin
					state_nxt = write_ok ? S_WDATA : S_IGNORE;              // [R12]
				end
			end
			S_SR_DATA: state_nxt = S_WAIT;
			S_IDLE, S_RDATA, S_WDATA, S_STAT_OUT, S_WAIT, S_IGNORE: state_nxt = state_r;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_d_r <= 1'b0;
			sel_d_r <= 1'b0;
			hold_r  <= 1'b0;
		end else if (ce) begin
			sck_d_r <= pin_s.sck;
			sel_d_r <= selected;
			hold_r  <= hold_nxt;
		end
	end

	// Serial receive side: counts, command, address and byte-wise actions.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r     <= S_IDLE;
			bit_idx_r   <= 3'h0;
			byte_cnt_r  <= 8'h0;
			shift_r     <= 8'h0;
			cmd_r       <= 8'h0;
			addr_r      <= 15'h0;
			new_sr_r    <= 8'h0;
			out_byte_r  <= 8'h0;
			page_mask_r <= 64'h0;
		end else if (ce) begin
			if (cs_start) begin
				state_r    <= S_CMD;
				bit_idx_r  <= 3'h0;
				byte_cnt_r <= 8'h0;
			end else if (!selected) begin
				state_r <= S_IDLE;                                           // [R10]
			end else if (sck_rise) begin
				shift_r   <= rx_byte;
				bit_idx_r <= bit_idx_r + 3'h1;
				if (byte_done) begin
					if (byte_cnt_r != 8'hff) begin
						byte_cnt_r <= byte_cnt_r + 8'h1;
					end
					state_r <= state_nxt;
					unique case (state_r)
						S_CMD: begin
							cmd_r      <= rx_byte;
							out_byte_r <= status_byte;
						end
						S_ADDR_HI: addr_r[14:8] <= rx_byte[6:0];            // [R09]
						S_ADDR_LO: begin
							addr_r      <= lo_addr;
							out_byte_r  <= rd_data;                         // [R09]
							page_mask_r <= 64'h0;
						end
						S_RDATA: begin
							addr_r     <= rd_addr;                          // [R09]
							out_byte_r <= rd_data;
						end
						S_WDATA: begin
							addr_r[5:0] <= addr_r[5:0] + 6'h1;              // [R11]
							page_mask_r[addr_r[5:0]] <= 1'b1;
						end
						S_SR_DATA: new_sr_r <= rx_byte;
						S_STAT_OUT: out_byte_r <= status_byte;
						S_IDLE, S_WAIT, S_IGNORE: cmd_r <= cmd_r;
					endcase
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (ce && sck_rise && byte_done && state_r == S_WDATA) begin
			pbuf[addr_r[5:0]] <= rx_byte;                                    // [R11]
		end
	end

	// Set wins over any clear arriving in the same cycle.
	assign wel_nxt = we_set ? 1'b1 : ((we_clr | prog_last) ? 1'b0 : wel_r); // [R05] [R14] [R26]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wip_r      <= 1'b0;
			prog_mem_r <= 1'b0;
			prog_cnt_r <= '0;
			page_r     <= 9'h0;
			sr_lock_r  <= 1'b0;
			sr_bp_r    <= 2'h0;
			wel_r      <= 1'b0;
		end else if (ce) begin
			wel_r <= wel_nxt;
			if (sr_start || mem_start) begin
				wip_r      <= 1'b1;                                          // [R05] [R27]
				prog_mem_r <= mem_start;
				prog_cnt_r <= '0;
				page_r     <= addr_r[14:6];
			end else if (wip_r) begin
				prog_cnt_r <= prog_cnt_r + 1'b1;
				if (prog_last) begin
					wip_r <= 1'b0;                                           // [R14]
					if (!prog_mem_r) begin
						sr_lock_r <= new_sr_r[`SEAP_SR_LOCK_BIT];            // [R01] [R06]
						sr_bp_r   <= new_sr_r[`SEAP_SR_GUARD_HI:`SEAP_SR_GUARD_LO];
					end
				end
			end
		end
	end

	// One buffered byte lands per cycle; the count must cover the whole page.
	wire [5:0] prog_idx = prog_cnt_r[5:0];
	always_ff @(posedge aclk) begin
		if (ce && wip_r && prog_mem_r && prog_cnt_r < `SEAP_PROG_CNT_W'(`SEAP_PAGE_BYTES) &&
			page_mask_r[prog_idx]) begin
			mem[{page_r, prog_idx}] <= pbuf[prog_idx];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			so_r    <= 1'b0;
			so_oe_r <= 1'b0;
		end else if (ce) begin
			so_oe_r <= selected & ~hold_nxt & out_state;                     // [R19]
			if (sck_fall && out_state) begin
				so_r <= out_byte_r[~bit_idx_r];                              // [R23]
			end
		end
	end

	assign so    = so_r;
	assign so_oe = so_oe_r;

	// Register slave: one write and one read at a time, answered one cycle after both
	// halves of a request are held.
	logic       aw_got_r;
	logic       w_got_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic       wstrb0_r;
	logic       awready_r;
	logic       wready_r;
	logic       bvalid_r;
	logic [1:0] bresp_r;
	logic       arready_r;
	logic       rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	wire aw_hs   = s_axi_awvalid & awready_r;
	wire w_hs    = s_axi_wvalid & wready_r;
	wire wr_go   = aw_got_r & w_got_r & ~bvalid_r;
	wire wr_ctrl = awaddr_r == `SEAP_REG_CTRL;
	wire wr_map  = wr_ctrl | (awaddr_r == `SEAP_REG_STATUS);
	wire rd_ctrl = s_axi_araddr == `SEAP_REG_CTRL;
	wire rd_stat = s_axi_araddr == `SEAP_REG_STATUS;
	wire [31:0] rd_word = rd_ctrl ? {31'h0, link_en_r} :
		rd_stat ? {22'h0, sel_d_r, hold_r, status_byte} : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awaddr_r  <= 8'h0;
			wdata_r   <= 32'h0;
			wstrb0_r  <= 1'b0;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= `SEAP_RESP_OKAY;
			link_en_r <= `SEAP_CTRL_RST;
		end else if (ce) begin
			if (aw_hs) begin
				aw_got_r  <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
				awready_r <= 1'b0;
			end
			if (w_hs) begin
				w_got_r  <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
				wready_r <= 1'b0;
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_map ? `SEAP_RESP_OKAY : `SEAP_RESP_SLVERR;
				if (wr_ctrl && wstrb0_r) begin
					link_en_r <= wdata_r[0];
				end
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r  <= 1'b0;
				aw_got_r  <= 1'b0;
				w_got_r   <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rresp_r   <= `SEAP_RESP_OKAY;
			rdata_r   <= 32'h0;
		end else if (ce) begin
			if (s_axi_arvalid && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rd_word;
				rresp_r   <= (rd_ctrl | rd_stat) ? `SEAP_RESP_OKAY : `SEAP_RESP_SLVERR;
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	a_wip_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R27]
		(ce && wip_r && !prog_last) |=> wip_r)
		else $error("Write in progress dropped before the programming count ended.");

	a_prog_done: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
		(ce && prog_last && !we_set) |=> (!wip_r && !wel_r))
		else $error("Programming end did not clear progress and latch.");

	a_sr_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
		(ce && wip_r && !prog_last) |=> ($stable(sr_lock_r) && $stable(sr_bp_r)))
		else $error("Protect bits changed while programming ran.");

	a_stat_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
		(state_r == S_STAT_OUT) |-> (out_byte_r[6:4] == 3'h0))
		else $error("Status bits 6 to 4 not zero.");

	a_hpm_block: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
		(ce && cs_end && hardware_guard_mode && state_r == S_WAIT && cmd_r == `SEAP_CMD_STATUS_WR)
		|=> !$rose(wip_r))
		else $error("Status write ran in hardware guard mode.");

	a_cmd_status_write_count: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
		(ce && cs_end && state_r == S_WAIT && cmd_r == `SEAP_CMD_STATUS_WR && !exact16)
		|=> !$rose(wip_r))
		else $error("Status write started with a wrong clock count.");

	a_read_busy: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
		(ce && selected && byte_done && state_r == S_CMD &&
		rx_byte == `SEAP_CMD_MEM_RD && wip_r) |=> (state_r == S_IGNORE))
		else $error("Memory read accepted while programming.");

	a_guard_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R12] [R15]
		(ce && selected && byte_done && state_r == S_ADDR_LO &&
		cmd_r == `SEAP_CMD_MEM_WR && seap_guarded(lo_addr, sr_bp_r)) |=> (state_r == S_IGNORE))
		else $error("Write accepted into a guarded block.");

	a_page_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
		(ce && selected && byte_done && state_r == S_WDATA)
		|=> (addr_r[14:6] == $past(addr_r[14:6])))
		else $error("Page write moved the upper address bits.");

	a_hold_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
		hold_r |-> !so_oe_r)
		else $error("Output driven during hold.");

endmodule

/* sim/seap_host_model.sv */
// Host-side serial controller model: drives select, link clock, data and pause.
// Assumes a 20 ns aclk; the link clock runs 160 ns, 100 ns low and 60 ns high.
`timescale 1ns/1ns
module seap_host_model (
	input  wire logic aclk,   // Bench clock that times every pin change.
	output logic      cs_n,   // Select, active low.
	output logic      sck,    // Link clock, low between frames.
	output logic      si,     // Data to the device.
	output logic      hold_n, // Pause, active low.
	input  wire logic so,     // Data from the device.
	input  wire logic so_oe   // High while the device drives so.
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic [7:0] r;
	logic       held_oe;
	logic       seen_oe;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Extra bits past the queued bytes spoil the clock count on purpose.
	task automatic frame(input int extra, input int hold_at);
		int n;
		n = tx_q.size() * 8 + extra;
		rx_q = {};
		seen_oe = 1'b0;
		cs_n <= 1'b0;
		tick(3);
		for (int i = 0; i < n; i++) begin
			if (hold_at > 0 && i == hold_at * 8) begin
				tick(1);
				hold_n <= 1'b0;
				tick(8);
				held_oe = so_oe;
				hold_n <= 1'b1;
				tick(4);
			end
			si <= (i < tx_q.size() * 8) ? tx_q[i / 8][7 - i % 8] : 1'b0;
			tick(5);
			r = {r[6:0], so};
			seen_oe |= so_oe;
			if (i % 8 == 7) rx_q.push_back(r);
			sck <= 1'b1;
			tick(3);
			sck <= 1'b0;
		end
		tick(4);
		cs_n <= 1'b1;
		si <= ~si;
		tick(6);
	endtask
endmodule

/* sim/seap_top_bench.sv */
// Self-checking bench for the serial memory command block.
// Assumes the host model is compiled first and the header is on the include path.
`timescale 1ns/1ns
`include "seap_cfg.svh"
module seap_top_bench;
	localparam int PROG = 256;
	logic        aclk, aresetn, wp_n, cs_n, sck, si, hold_n, so, so_oe;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          bad_count, tests_run, cycles;

	seap_top #(.PROG_CYCLES(PROG)) seap_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n), .so(so), .so_oe(so_oe),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	seap_host_model seap_host_model_inst (.aclk(aclk), .cs_n(cs_n), .sck(sck), .si(si),
		.hold_n(hold_n), .so(so), .so_oe(so_oe));

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check_word({30'h0, bresp}, {30'h0, er});
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		rready <= 1'b0;
		check_word({30'h0, rresp}, {30'h0, er});
		@(posedge aclk);
	endtask
	task automatic status_is(input logic [7:0] e);
		logic [31:0] d;
		axi_rd(8'h00, 2'h0, d);
		check_word({24'h0, d[7:0]}, {24'h0, e});
	endtask
	task automatic send(input logic [31:0] w, input int nb, input int extra);
		seap_host_model_inst.tx_q = {};
		for (int i = 0; i < nb; i++)
			seap_host_model_inst.tx_q.push_back(i < 4 ? w[31 - 8 * i -: 8] : 8'h00);
		seap_host_model_inst.frame(extra, 0);
	endtask
	task automatic cmd_set_write_enable();
		send({`SEAP_CMD_SET_WE, 24'h0}, 1, 0);
	endtask
	task automatic wait_prog();
		repeat (PROG + 16) @(posedge aclk);
	endtask
	function automatic logic [31:0] rx(input int k);
		return {24'h0, seap_host_model_inst.rx_q[k]};
	endfunction

	task automatic test_regs();
		logic [31:0] d;
		axi_rd(8'h10, 2'h2, d);
		check_word(d, 32'h0);
		axi_wr(8'h00, 32'hff, 2'h0);
		axi_wr(8'h04, 32'h0, 2'h0);
		cmd_set_write_enable();
		status_is(8'h00);
		axi_wr(8'h04, 32'h1, 2'h0);
		$display("done registers");
	endtask
	task automatic test_status();
		cmd_set_write_enable();
		send({`SEAP_CMD_STATUS_WR, 8'hff, 16'h0}, 2, 0);
		status_is(8'h03);
		wait_prog();
		status_is(8'h8c);
		$display("done status write");
	endtask
	task automatic test_hw();
		wp_n <= 1'b0;
		cmd_set_write_enable();
		send({`SEAP_CMD_STATUS_WR, 24'h0}, 2, 0);
		status_is(8'h8e);
		wp_n <= 1'b1;
		send({`SEAP_CMD_STATUS_WR, 8'h04, 16'h0}, 2, 0);
		wait_prog();
		status_is(8'h04);
		wp_n <= 1'b0;
		cmd_set_write_enable();
		send({`SEAP_CMD_STATUS_WR, 24'h0}, 2, 0);
		wait_prog();
		status_is(8'h00);
		$display("done hardware guard");
	endtask
	task automatic test_cancel();
		cmd_set_write_enable();
		send({`SEAP_CMD_STATUS_WR, 8'h0c, 16'h0}, 2, 1);
		status_is(8'h02);
		send({`SEAP_CMD_MEM_WR, 16'h0010, 8'haa}, 4, 4);
		status_is(8'h02);
		send({`SEAP_CMD_CLEAR_WE, 24'h0}, 1, 0);
		status_is(8'h00);
		send({`SEAP_CMD_MEM_WR, 16'h0010, 8'haa}, 4, 0);
		status_is(8'h00);
		$display("done cancel");
	endtask
	task automatic test_page();
		cmd_set_write_enable();
		seap_host_model_inst.tx_q = {`SEAP_CMD_MEM_WR, 8'h80, 8'h3e};
		for (int k = 0; k < 66; k++) seap_host_model_inst.tx_q.push_back(8'h10 + 8'(k));
		seap_host_model_inst.frame(0, 0);
		status_is(8'h03);
		send({`SEAP_CMD_MEM_RD, 24'h0}, 5, 0);
		check_word({31'h0, seap_host_model_inst.seen_oe}, 32'h0);
		wait_prog();
		status_is(8'h00);
		cmd_set_write_enable();
		send({`SEAP_CMD_MEM_WR, 16'hffff, 8'ha5}, 4, 0);
		wait_prog();
		send({`SEAP_CMD_MEM_RD, 16'hffff, 8'h00}, 5, 0);
		check_word(rx(3), 32'ha5);
		check_word(rx(4), 32'h12);
		seap_host_model_inst.tx_q = {`SEAP_CMD_MEM_RD, 8'h00, 8'h3e, 8'h00, 8'h00};
		seap_host_model_inst.frame(0, 4);
		check_word(rx(3), 32'h50);
		check_word(rx(4), 32'h51);
		check_word({31'h0, seap_host_model_inst.held_oe}, 32'h0);
		$display("done page write");
	endtask
	task automatic test_guard();
		logic [15:0] a [4] = '{16'h7fff, 16'h6000, 16'h4000, 16'h0000};
		for (int g = 1; g < 4; g++) begin
			cmd_set_write_enable();
			send({`SEAP_CMD_STATUS_WR, 4'h0, 2'(g), 2'b00, 16'h0}, 2, 0);
			wait_prog();
			cmd_set_write_enable();
			send({`SEAP_CMD_MEM_WR, a[g], 8'h00}, 4, 0);
			status_is({4'h0, 2'(g), 2'b10});
			if (g < 3) begin
				send({`SEAP_CMD_MEM_WR, a[g] - 16'h1, 8'h00}, 4, 0);
				status_is({4'h0, 2'(g), 2'b11});
				wait_prog();
			end
		end
		$display("done block guard");
	endtask

	always #10 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, bad_count, tests_run, cycles} = '0;
		wp_n = 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		test_regs();
		test_status();
		test_hw();
		test_cancel();
		test_page();
		test_guard();
		complete_run();
	end
endmodule
